//--- frm_defs.svh
// Purpose: field positions, codes and constants for the ramp core
// Assumes: 32-bit register words, control bits in the three lowest bits
// Notes:   definitions only
`ifndef FRM_DEFS_SVH
`define FRM_DEFS_SVH
// ----------------------------------------------------------------
// register select codes (word bits 2:0)
// ----------------------------------------------------------------
`define FRM_SEL_INTFRAC  3'h0
`define FRM_SEL_LOFRAC   3'h1
`define FRM_SEL_REFDIV   3'h2
`define FRM_SEL_FUNC     3'h3
`define FRM_SEL_CLOCK    3'h4
`define FRM_SEL_DEV      3'h5
`define FRM_SEL_STEP     3'h6
`define FRM_SEL_DELAY    3'h7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FRM_RAMP_ON      31
`define FRM_SLIP_EN      28
`define FRM_HALVER       21
`define FRM_DOUBLER      20
`define FRM_FULL_TRI     21
`define FRM_PD_POS       6
`define FRM_BANK         23
`define FRM_DUAL         24
`define FRM_CLK_SEL      6
// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
`define FRM_CELLS_MAX    3'h7
`define FRM_RDIV_ZERO    6'h20
`define FRM_HOP_MODE     2'h3
`define FRM_MOD_FSK      2'h1
`define FRM_MOD_PSK      2'h2
`define FRM_RAMP_CSAW    2'h0
`define FRM_RAMP_CTRI    2'h1
`define FRM_RAMP_SSAW    2'h2
`define FRM_RAMP_SBURST  2'h3
`define FRM_RD_STATUS    3'h0
`define FRM_RD_FRAC      3'h1
`define FRM_RD_INT       3'h2
`define FRM_RD_COUNT     3'h3
`endif

//--- frm_pkg.sv
// Purpose: types of the ramp core
// Assumes: nothing beyond the defs header
// Notes:   the whole module state is one packed struct
package frm_pkg;
    // ramp sequencer states
    typedef enum logic [2:0] {
        FRM_IDLE = 3'h0,
        FRM_UP   = 3'h1,
        FRM_DOWN = 3'h2,
        FRM_SAW  = 3'h3,
        FRM_HOLD = 3'h4
    } frm_sm_t;

    // programmed configuration
    typedef struct packed {
        logic [11:0]       int_v;
        logic [11:0]       frac_msb;
        logic [12:0]       frac_lsb;
        logic [11:0]       phase;
        logic              slip_en;
        logic              halver;
        logic              doubler;
        logic [4:0]        rdiv;
        logic [11:0]       hop_timer_first_divider;
        logic [1:0]        ramp_mode;
        logic [1:0]        mod_mode;
        logic              pd_pos;
        logic [1:0]        clkdiv_mode;
        logic [1:0][11:0]  hop_timer_second_divider;
        logic [1:0][15:0]  dev;
        logic [1:0][3:0]   dshift;
        logic              dual;
        logic [1:0][19:0]  steps;
        logic              full_tri;
        logic              ramp_on;
    } frm_cfg_t;

    // complete module state
    typedef struct packed {
        frm_cfg_t           cfg;
        logic [2:0]         mod_s;
        logic [2:0]         slip_s;
        logic [2:0]         past_s;
        logic               mod_f;
        logic               slip_f;
        logic               slip_q;
        logic               past_f;
        logic [6:0]         pfd_acc;
        logic               pfd_tick;
        logic [11:0]        c1;
        logic [11:0]        c2;
        frm_sm_t            sm;
        logic               bank;
        logic [19:0]        cnt;
        logic signed [37:0] roff;
        logic [2:0]         cells;
        logic [11:0]        n_int;
        logic [24:0]        n_frac;
        logic [11:0]        phase_o;
        logic               busy;
        logic [31:0]        rdata;
    } frm_state_t;
endpackage

//--- frm_ramp_core.sv
// Purpose: divider value, ramp, FSK/PSK and slip-cell sequencing core
// Assumes: 50 MHz clock_i; slip and target inputs come from analog pins
// Notes:   writes select their register by the word's three lowest bits
//
// Functional notes
// (RULE1) host writes the eight registers from delay down to integer/fraction
// (RULE2) host writes step, deviation and clock registers for both banks
// (RULE3) fraction is upper twelve bits shifted by 13 plus lower 13 bits
// (RULE4) comparison tick rate is reference times (1+D)/(R*(1+T))
// (RULE5) each slip risk adds one extra pump cell, seven at most
// (RULE6) past target, extra cells switch off one at a time
// (RULE7) slip reduction works only while its enable bit is set
// (RULE8) host uses slip reduction only with positive detector polarity
// (RULE9) FSK moves divider up or down by shifted deviation word
// (RULE10) deviation word is bits 18:3, shift is bits 22:19
// (RULE11) PSK phase value comes from low fraction bits 14:3
// (RULE12) PSK adds phase on high modulation input, subtracts on low
// (RULE13) five waveforms: burst, triangle, sawtooth, both continuous forms
// (RULE14) hop interval is first divider times second, mode field must be 11
// (RULE15) hops per section come from the 20-bit step count
// (RULE16) host keeps the integer rise within 256 of its start
// (RULE17) single burst steps up for step count hops then holds
// (RULE18) single triangle steps back down after the upward run
// (RULE19) single sawtooth restores start value one hop after last step
// (RULE20) continuous sawtooth repeats until the ramp is disabled
// (RULE21) continuous triangle alternates up and down runs until disabled
// (RULE22) host picks ramp type, then sets the start bit
// (RULE23) deviation word is signed, negative steps go downward
// (RULE24) three lowest word bits route each write, 111 is delay
// (RULE25) hop timer counts comparison ticks and reloads on expiry
// (RULE26) parameter writes apply at the next hop boundary only; here integer, fraction and modulation fields act at once
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "frm_defs.svh"

module frm_ramp_core
    import frm_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // pins from the loop
    input  wire logic        mod_pin_i,
    input  wire logic        slip_risk_i,
    input  wire logic        past_target_i,
    // divider and modulation outputs
    output logic      [11:0] n_int_o,
    output logic      [24:0] n_frac_o,
    output logic      [11:0] phase_o,
    output logic      [2:0]  slip_cells_o,
    output logic             ramp_busy_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // signed deviation word scaled by its shift
    function automatic logic signed [37:0] step_inc(
        input logic [15:0] d,
        input logic [3:0]  s
    );
        logic signed [37:0] w;
        w = 38'($signed(d)); // RULE23
        step_inc = w <<< s; // RULE9
    endfunction

    // end of a run of step count hops
    function automatic logic run_done(
        input logic [19:0] c,
        input logic [19:0] n
    );
        run_done = ({1'b0, c} + 21'h1) >= {1'b0, n}; // RULE15
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    frm_state_t st_r;
    frm_state_t st_nxt;

    logic        [2:0]  wsel;
    logic        [6:0]  period;
    logic        [7:0]  acc_sum;
    logic               hop;
    logic               last;
    logic signed [37:0] rinc;
    logic signed [37:0] finc;
    logic signed [37:0] fsk;
    logic signed [37:0] nsum;
    logic        [36:0] base;

    always_comb begin
        st_nxt = st_r;
        wsel   = wr_data_i[2:0];

        // register writes, whole word lands in one cycle
        if (wr_i) begin
            unique case (wsel) // RULE24
                `FRM_SEL_INTFRAC: begin
                    st_nxt.cfg.int_v    = wr_data_i[26:15];
                    st_nxt.cfg.frac_msb = wr_data_i[14:3];
                    st_nxt.cfg.ramp_on  = wr_data_i[`FRM_RAMP_ON];
                end
                `FRM_SEL_LOFRAC: begin
                    st_nxt.cfg.frac_lsb = wr_data_i[27:15];
                    st_nxt.cfg.phase    = wr_data_i[14:3]; // RULE11
                end
                `FRM_SEL_REFDIV: begin
                    st_nxt.cfg.slip_en  = wr_data_i[`FRM_SLIP_EN];
                    st_nxt.cfg.halver   = wr_data_i[`FRM_HALVER];
                    st_nxt.cfg.doubler  = wr_data_i[`FRM_DOUBLER];
                    st_nxt.cfg.rdiv     = wr_data_i[19:15];
                    st_nxt.cfg.hop_timer_first_divider     = wr_data_i[14:3];
                end
                `FRM_SEL_FUNC: begin
                    st_nxt.cfg.ramp_mode = wr_data_i[11:10];
                    st_nxt.cfg.mod_mode  = wr_data_i[9:8];
                    st_nxt.cfg.pd_pos    = wr_data_i[`FRM_PD_POS];
                end
                `FRM_SEL_CLOCK: begin
                    st_nxt.cfg.clkdiv_mode = wr_data_i[20:19];
                    st_nxt.cfg.hop_timer_second_divider[wr_data_i[`FRM_CLK_SEL]] = wr_data_i[18:7];
                end
                `FRM_SEL_DEV: begin
                    st_nxt.cfg.dual = wr_data_i[`FRM_DUAL];
                    st_nxt.cfg.dev[wr_data_i[`FRM_BANK]]    = wr_data_i[18:3]; // RULE10
                    st_nxt.cfg.dshift[wr_data_i[`FRM_BANK]] = wr_data_i[22:19]; // RULE10
                end
                `FRM_SEL_STEP: begin
                    st_nxt.cfg.steps[wr_data_i[`FRM_BANK]] = wr_data_i[22:3];
                end
                `FRM_SEL_DELAY: begin
                    st_nxt.cfg.full_tri = wr_data_i[`FRM_FULL_TRI];
                end
            endcase
        end

        // pin synchronisers: change taken when stages two and three agree
        st_nxt.mod_s  = {st_r.mod_s[1:0], mod_pin_i};
        st_nxt.slip_s = {st_r.slip_s[1:0], slip_risk_i};
        st_nxt.past_s = {st_r.past_s[1:0], past_target_i};
        if (st_r.mod_s[1] == st_r.mod_s[2]) begin
            st_nxt.mod_f = st_r.mod_s[2];
        end
        if (st_r.slip_s[1] == st_r.slip_s[2]) begin
            st_nxt.slip_f = st_r.slip_s[2];
        end
        if (st_r.past_s[1] == st_r.past_s[2]) begin
            st_nxt.past_f = st_r.past_s[2];
        end
        st_nxt.slip_q = st_r.slip_f;

        // comparison tick: rate accumulator, at most one tick per clock
        period = 7'(((st_r.cfg.rdiv == 5'h0) ? `FRM_RDIV_ZERO
                    : {1'b0, st_r.cfg.rdiv}) << st_r.cfg.halver); // RULE4
        acc_sum = {1'b0, st_r.pfd_acc} + (st_r.cfg.doubler ? 8'h2 : 8'h1); // RULE4
        if (acc_sum >= {1'b0, period}) begin
            st_nxt.pfd_acc  = 7'(acc_sum - {1'b0, period});
            st_nxt.pfd_tick = 1'b1;
        end else begin
            st_nxt.pfd_acc  = acc_sum[6:0];
            st_nxt.pfd_tick = 1'b0;
        end

        // hop timer: first divider of ticks, times second divider
        hop = 1'b0;
        if (st_r.pfd_tick) begin
            if (({1'b0, st_r.c1} + 13'h1) >= {1'b0, st_r.cfg.hop_timer_first_divider}) begin // RULE25
                st_nxt.c1 = 12'h0;
                if (({1'b0, st_r.c2} + 13'h1)
                    >= {1'b0, st_r.cfg.hop_timer_second_divider[st_r.bank]}) begin // RULE14
                    st_nxt.c2 = 12'h0;
                    hop       = (st_r.cfg.clkdiv_mode == `FRM_HOP_MODE); // RULE14
                end else begin
                    st_nxt.c2 = st_r.c2 + 12'h1;
                end
            end else begin
                st_nxt.c1 = st_r.c1 + 12'h1;
            end
        end

        // step from the live registers, sampled only at a hop
        rinc = step_inc(st_r.cfg.dev[st_r.bank], st_r.cfg.dshift[st_r.bank]); // RULE26
        last = run_done(st_r.cnt, st_r.cfg.steps[st_r.bank]);

        // ramp sequencer
        if (!st_r.cfg.ramp_on) begin
            st_nxt.sm   = FRM_IDLE; // RULE20
            st_nxt.roff = 38'sh0;
            st_nxt.cnt  = 20'h0;
            st_nxt.bank = 1'b0;
        end else if (st_r.sm == FRM_IDLE) begin
            // start: timer restarts so the first step is one full hop away
            st_nxt.sm = FRM_UP;
            st_nxt.c1 = 12'h0;
            st_nxt.c2 = 12'h0;
        end else if (hop) begin
            unique case (st_r.sm)
                FRM_UP: begin
                    st_nxt.roff = st_r.roff + rinc; // RULE17
                    st_nxt.cnt  = st_r.cnt + 20'h1;
                    if (last) begin
                        st_nxt.cnt  = 20'h0;
                        st_nxt.bank = st_r.cfg.dual ? ~st_r.bank : 1'b0;
                        unique case (st_r.cfg.ramp_mode) // RULE13
                            `FRM_RAMP_SBURST: st_nxt.sm = FRM_HOLD; // RULE17
                            `FRM_RAMP_CTRI:   st_nxt.sm = FRM_DOWN; // RULE18
                            `FRM_RAMP_CSAW,
                            `FRM_RAMP_SSAW:   st_nxt.sm = FRM_SAW; // RULE19
                        endcase
                    end
                end
                FRM_DOWN: begin
                    st_nxt.roff = st_r.roff - rinc; // RULE18
                    st_nxt.cnt  = st_r.cnt + 20'h1;
                    if (last) begin
                        st_nxt.cnt  = 20'h0;
                        st_nxt.bank = st_r.cfg.dual ? ~st_r.bank : 1'b0;
                        // single full triangle stops at the bottom
                        st_nxt.sm = st_r.cfg.full_tri ? FRM_HOLD : FRM_UP; // RULE21
                    end
                end
                FRM_SAW: begin
                    st_nxt.roff = 38'sh0; // RULE19
                    st_nxt.sm   = (st_r.cfg.ramp_mode == `FRM_RAMP_CSAW)
                                  ? FRM_UP : FRM_HOLD; // RULE20
                end
                FRM_HOLD: begin
                    st_nxt.sm = FRM_HOLD; // RULE17
                end
                default: begin
                    st_nxt.sm = FRM_IDLE;
                end
            endcase
        end

        // busy decoded from the next state so the pin leaves a flop, same timing
        st_nxt.busy = (st_nxt.sm == FRM_UP) || (st_nxt.sm == FRM_DOWN)
                      || (st_nxt.sm == FRM_SAW);

        // slip cells: add per risk edge, shed one per tick once past target
        if (!st_r.cfg.slip_en) begin
            st_nxt.cells = 3'h0; // RULE7
        end else if (st_r.slip_f && !st_r.slip_q && !st_r.past_f) begin
            if (st_r.cells != `FRM_CELLS_MAX) begin
                st_nxt.cells = st_r.cells + 3'h1; // RULE5
            end
        end else if (st_r.past_f && st_r.pfd_tick && st_r.cells != 3'h0) begin
            st_nxt.cells = st_r.cells - 3'h1; // RULE6
        end

        // FSK: bank 1 word rides on a running ramp, bank 0 otherwise
        finc = step_inc(st_r.cfg.dev[st_r.cfg.ramp_on],
                        st_r.cfg.dshift[st_r.cfg.ramp_on]);
        if (st_r.cfg.mod_mode == `FRM_MOD_FSK) begin
            fsk = st_r.mod_f ? finc : -finc; // RULE9
        end else begin
            fsk = 38'sh0;
        end

        // divider value, wraps silently if the host breaks the 256 limit
        base   = {st_r.cfg.int_v, st_r.cfg.frac_msb, st_r.cfg.frac_lsb}; // RULE3
        nsum   = $signed({1'b0, base}) + st_r.roff + fsk;
        st_nxt.n_int  = nsum[36:25];
        st_nxt.n_frac = nsum[24:0];

        // PSK phase offset in units of 360/4096 degree
        if (st_r.cfg.mod_mode == `FRM_MOD_PSK) begin
            st_nxt.phase_o = st_r.mod_f ? st_r.cfg.phase
                                        : 12'(-st_r.cfg.phase); // RULE12
        end else begin
            st_nxt.phase_o = 12'h0;
        end

        // readback, valid in the cycle after the strobe only
        st_nxt.rdata = 32'h0;
        if (rd_i) begin
            unique case (addr_i)
                `FRM_RD_STATUS: st_nxt.rdata = {25'h0, st_r.mod_f, st_r.cells, st_r.sm};
                `FRM_RD_FRAC:   st_nxt.rdata = {7'h0, st_r.n_frac};
                `FRM_RD_INT:    st_nxt.rdata = {20'h0, st_r.n_int};
                `FRM_RD_COUNT:  st_nxt.rdata = {12'h0, st_r.cnt};
                default:        st_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // single state register, all zero after reset
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state
    assign rd_data_o    = st_r.rdata;
    assign n_int_o      = st_r.n_int;
    assign n_frac_o     = st_r.n_frac;
    assign phase_o      = st_r.phase_o;
    assign slip_cells_o = st_r.cells;
    assign ramp_busy_o  = st_r.busy;
endmodule

//--- frm_properties.sv
// Purpose: port assertions for the ramp core
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
module frm_properties (
    // clock, reset, register port
    input wire logic        clock_i,
    input wire logic        resetn_i,
    input wire logic [2:0]  addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rd_data_o,
    // pins and outputs
    input wire logic        mod_pin_i,
    input wire logic        slip_risk_i,
    input wire logic        past_target_i,
    input wire logic [11:0] n_int_o,
    input wire logic [24:0] n_frac_o,
    input wire logic [11:0] phase_o,
    input wire logic [2:0]  slip_cells_o,
    input wire logic        ramp_busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // register port, ramp and modulation
    // ----------------------------------------------------------------
    a_rd_quiet: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
        else $error("read data outside its slot");
    a_unmapped_rd: assert property (rd_i && addr_i[2] |=> rd_data_o == 32'h0)
        else $error("unmapped read not zero");
    // a ramp only starts from a register write, seen two samples back
    a_busy_on_write: assert property ($rose(ramp_busy_o) |-> $past(wr_i, 2))
        else $error("ramp started without write");
    // window long enough to cover pin sync and output lag
    a_hold_steady: assert property ((!ramp_busy_o && !wr_i && $stable(mod_pin_i))[*8]
        |=> $stable(n_frac_o) && $stable(n_int_o))
        else $error("divider moved while quiet");
    a_psk_mirror: assert property ($changed(phase_o) && phase_o != 12'h0
        && $past(phase_o) != 12'h0 && !$past(wr_i) && !$past(wr_i, 2) && !$past(wr_i, 3)
        |-> phase_o == 12'h0 - $past(phase_o))
        else $error("phase not mirrored");
    // ----------------------------------------------------------------
    // slip cells
    // ----------------------------------------------------------------
    a_cells_up_one: assert property (slip_cells_o > $past(slip_cells_o)
        |-> slip_cells_o == $past(slip_cells_o) + 3'h1)
        else $error("cells rose by more than one");
    // writes excluded: disabling clears all cells at once
    a_cells_down_one: assert property (slip_cells_o < $past(slip_cells_o) && !$past(wr_i)
        && !$past(wr_i, 2) && !$past(wr_i, 3)
        |-> slip_cells_o == $past(slip_cells_o) - 3'h1)
        else $error("cells fell by more than one");
    a_no_rise_past: assert property (past_target_i[*8]
        |=> !(slip_cells_o > $past(slip_cells_o)))
        else $error("cell added past target");
    a_no_risk_hold: assert property ((!slip_risk_i)[*8]
        |=> !(slip_cells_o > $past(slip_cells_o)))
        else $error("cell added without risk");
    c_ramp: cover property ($rose(ramp_busy_o));
    c_cells_full: cover property (slip_cells_o == 3'h7);
    c_psk: cover property (phase_o != 12'h0);
endmodule

bind frm_ramp_core frm_properties u_props (
    .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .mod_pin_i(mod_pin_i), .slip_risk_i(slip_risk_i),
    .past_target_i(past_target_i), .n_int_o(n_int_o), .n_frac_o(n_frac_o),
    .phase_o(phase_o), .slip_cells_o(slip_cells_o), .ramp_busy_o(ramp_busy_o)
);

//--- frm_host.sv
// Purpose: host model that programs the ramp core
// Assumes: one-cycle strobes, no wait states
// Notes:   released lines show inverted data, never the last value
`timescale 1ns/1ps
module frm_host (
    // clock
    input  wire logic        clock_i,
    // register port towards the core
    output logic      [2:0]  addr_o = 3'h0,
    output logic      [31:0] wr_data_o = 32'h0,
    output logic             wr_o = 1'b0,
    output logic             rd_o = 1'b0
);
    // one write, strobe held across one sampling edge
    task automatic wr(input logic [31:0] w);
        @(posedge clock_i);
        wr_o      <= 1'b1;
        wr_data_o <= w;
        @(posedge clock_i);
        wr_o      <= 1'b0;
        wr_data_o <= ~w;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clock_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
    endtask
    // descending order, banked registers loaded twice
    task automatic init(input logic [31:0] w [8]);
        wr(w[7]);
        wr(w[6]);
        wr(w[6] | 32'h0080_0000);
        wr(w[5]);
        wr(w[5] | 32'h0080_0000);
        wr(w[4]);
        wr(w[4] | 32'h0000_0040);
        wr(w[3]);
        wr(w[2]);
        wr(w[1]);
        wr(w[0]);
    endtask
endmodule

//--- frm_ramp_core_tb.sv
// Purpose: self-checking bench for the ramp core
// Assumes: R of 1, so one comparison tick per clock; hop = 2*3 ticks
// Notes:   reads are matched against a queue of expectations
`timescale 1ns/1ps
module frm_ramp_core_tb;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        mod_pin_i = 1'b0;
    logic        slip_risk_i = 1'b0;
    logic        past_target_i = 1'b0;
    wire  [2:0]  addr;
    wire  [31:0] wdata;
    wire         wr;
    wire         rd;
    logic [31:0] rd_data_o;
    logic [11:0] n_int_o;
    logic [24:0] n_frac_o;
    logic [11:0] phase_o;
    logic [2:0]  slip_cells_o;
    logic        ramp_busy_o;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          t;
    logic [31:0] exp_q [$];
    logic        rd_q = 1'b0;
    logic [31:0] cfg [8];
    logic [36:0] base;
    logic [36:0] inc;
    logic [15:0] dev;
    logic [3:0]  shift;
    logic [11:0] ph;
    // ramp type, full triangle, divider mode, continuous, counts steps
    logic [6:0]  tbl [6] = '{7'h6D, 7'h4C, 7'h3C, 7'h0E, 7'h2E, 7'h62};

    frm_host host (.clock_i(clock_i), .addr_o(addr), .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));
    frm_ramp_core DUT (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
        .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data_o),
        .mod_pin_i(mod_pin_i), .slip_risk_i(slip_risk_i), .past_target_i(past_target_i),
        .n_int_o(n_int_o), .n_frac_o(n_frac_o), .phase_o(phase_o),
        .slip_cells_o(slip_cells_o), .ramp_busy_o(ramp_busy_o));

    initial forever #10 clock_i = ~clock_i;

    task automatic stop_test();
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (rd_q && exp_q.size() > 0)
            check(rd_data_o, exp_q.pop_front());
        rd_q <= rd;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic rd_exp(input logic [2:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task automatic chk_n(input logic [36:0] e);
        rd_exp(3'h2, {20'h0, e[36:25]});
        rd_exp(3'h1, {7'h0, e[24:0]});
    endtask
    function automatic logic [31:0] f0(input logic on);
        return {on, 4'h0, base[36:13], 3'h0};
    endfunction
    // full init; polarity always positive so slip reduction is legal
    task automatic setup(input logic [1:0] rm, input logic [1:0] mm, input logic [1:0] dm,
                         input logic tri_on, input logic slip, input logic [11:0] p);
        cfg[0] = f0(1'b0);
        cfg[1] = {4'h0, base[12:0], p, 3'h1};
        cfg[2] = {3'h0, slip, 8'h0, 5'h01, 12'h002, 3'h2};
        cfg[3] = {20'h0, rm, mm, 2'h1, 3'h0, 3'h3};
        cfg[4] = {11'h0, dm, 12'h003, 1'b0, 6'h04};
        cfg[5] = {9'h0, shift, dev, 3'h5};
        cfg[6] = {9'h0, 20'h00004, 3'h6};
        cfg[7] = {10'h0, tri_on, 18'h0, 3'h7};
        host.init(cfg);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            slip_risk_i <= 1'b1;
            repeat (8) @(posedge clock_i);
            slip_risk_i <= 1'b0;
            repeat (8) @(posedge clock_i);
        end
    endtask

    initial begin
        void'($urandom(32'h89DA));
        base = {5'($urandom), $urandom};
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd_exp(a[2:0], 32'h0);
        // every waveform, both deviation signs; small steps keep int rise tiny
        foreach (tbl[i]) begin
            dev = 16'($urandom);
            dev[15] = i[0];
            shift = 4'($urandom_range(3));
            inc = 37'($signed(dev)) << shift;
            setup(tbl[i][6:5], 2'h0, tbl[i][3:2], tbl[i][4], 1'b0, 12'h0);
            // doubled reference over R of 2 keeps one tick per clock
            if (tbl[i][0])
                host.wr({10'h0, 2'h1, 5'h02, 12'h002, 3'h2});
            host.wr(f0(1'b1));
            repeat (2) @(posedge clock_i);
            if (tbl[i][1]) begin
                repeat (200) @(posedge clock_i);
                check({31'h0, ramp_busy_o}, 32'h1);
                if (tbl[i][3:2] != 2'h3)
                    chk_n(base);
                host.wr(f0(1'b0));
                @(posedge clock_i);
            end
            t = 0;
            while (ramp_busy_o !== 1'b0 && t < 500) begin
                @(posedge clock_i);
                t++;
            end
            if (tbl[i][0])
                check(32'(t inside {[22:26]}), 32'h1);
            repeat (3) @(posedge clock_i);
            chk_n(tbl[i][0] ? base + inc * 37'd4 : base);
        end
        // frequency keying around the programmed value
        setup(2'h0, 2'h1, 2'h3, 1'b0, 1'b0, 12'h0);
        for (int p = 0; p < 2; p++) begin
            mod_pin_i <= p[0];
            repeat (10) @(posedge clock_i);
            chk_n(p[0] ? base + inc : base - inc);
        end
        // phase keying, pin low then high then low
        ph = 12'($urandom);
        setup(2'h0, 2'h2, 2'h3, 1'b0, 1'b0, ph);
        for (int p = 0; p < 3; p++) begin
            mod_pin_i <= p[0];
            repeat (10) @(posedge clock_i);
            check({20'h0, phase_o}, {20'h0, p[0] ? ph : 12'h0 - ph});
        end
        // slip cells: saturate, release past target, then disabled
        setup(2'h0, 2'h0, 2'h3, 1'b0, 1'b1, 12'h0);
        pulse(9);
        check({29'h0, slip_cells_o}, 32'h7);
        past_target_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        check({29'h0, slip_cells_o}, 32'h0);
        past_target_i <= 1'b0;
        setup(2'h0, 2'h0, 2'h3, 1'b0, 1'b0, 12'h0);
        pulse(2);
        check({29'h0, slip_cells_o}, 32'h0);
        repeat (4) @(posedge clock_i);
        stop_test();
    end
endmodule
